// ==== rtl/ulms_pkg.sv ====
// constants, types and field layout of the line and modem status block
// assumes an 8-bit special-function-register port on the system clock
//
// What this block does
// - loopback forces serial out high, tx feeds rx
// - loopback routes control outputs to modem inputs
// - driver enable high while tx FIFO non-empty
// - half duplex: receiver enable low idle only
// - full duplex modes keep receiver enable low
// - data present flag mirrors rx FIFO non-empty
// - overrun when rx FIFO full, FIFO untouched
// - parity flag reports FIFO head character
// - framing flag reports FIFO head character
// - break pushes zero character and sets flag
// - overrun, parity, framing, break flags clear on line status read
// - tx FIFO empty flag, cleared by write
// - idle flag needs FIFO and shifter empty
// - error summary while bad character held
// - CTS, DSR, DCD change flags, clear on read
// - ring flag only on RI low-to-high
// - upper modem bits show inverted inputs or loopback
// - DTR and RTS pins are inverted control bits
// - modem status read clears modem interrupt
// - line status read clears line interrupt

package ulms_pkg;

  // register addresses on the port
  localparam logic [7:0] ADDR_DATA = 8'hE1;
  localparam logic [7:0] ADDR_MCR = 8'hE5;
  localparam logic [7:0] ADDR_LSR = 8'hE6;
  localparam logic [7:0] ADDR_MSR = 8'hE7;

  // modem control fields
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_AUX1 = 2;
  localparam int MCR_AUX2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_DIR_LO = 6;
  localparam int MCR_DIR_HI = 7;
  localparam logic [7:0] MCR_RESET = 8'h00;

  // line status fields
  localparam int LSR_DATA_PRESENT = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_TX_EMPTY = 5;

  // read value of write-only and unmapped addresses
  localparam logic [7:0] READ_NONE = 8'h00;

  // fifo geometry
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] FIFO_ZERO = 5'h00;
  localparam logic [4:0] FIFO_ONE = 5'h01;
  localparam logic [3:0] PTR_ONE = 4'h1;

  // line driver direction modes
  typedef enum logic [1:0] {
    DIR_RX_OFF = 2'h0,
    DIR_HALF = 2'h1,
    DIR_FULL_SLAVE = 2'h2,
    DIR_FULL_MASTER = 2'h3
  } ulms_dir_t;

  // one received character with its error marks
  typedef struct packed {
    logic brk;
    logic stopBad;
    logic parityBad;
    logic [7:0] data;
  } ulms_rxchar_t;

  // modem handshake lines, one bit each
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ulms_modem_t;

  // idle level of the active-low modem pins
  localparam ulms_modem_t MODEM_IDLE = 4'hF;

endpackage

// ==== rtl/ulms_sync.sv ====
// two-flop synchroniser for a vector of pin inputs
// assumes each bit is an independent level; no bus coherence
`timescale 1ns/1ps
`default_nettype none

module ulms_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins and result
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] syncOut
);

  // first stage, read only by the second
  logic [W-1:0] meta;

  ////////////////////////////////////////////////////////////////
  // two stages per bit
  genvar i;
  for (i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge sys_clk)
    begin
      if (rst)
      begin
        meta[i] <= INIT[i];
        syncOut[i] <= INIT[i];
      end
      else
      begin
        meta[i] <= pinIn[i];
        syncOut[i] <= meta[i];
      end
    end
  end

endmodule

`default_nettype wire

// ==== rtl/ulms_skid.sv ====
// two-entry buffer with valid and ready on both sides
// assumes source and sink on the same clock
`timescale 1ns/1ps
`default_nettype none

module ulms_skid (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  input wire logic [7:0] inData,
  output logic inReady,
  // draining side
  input wire logic outReady,
  output logic outValid,
  output logic [7:0] outData
);

  // spare entry for a stalled sink
  logic spareValid;
  logic [7:0] spare;

  // room while the spare entry is free
  assign inReady = ~spareValid;

  ////////////////////////////////////////////////////////////////
  // output entry refills from spare first, then from input
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      outValid <= 1'b0;
      outData <= 8'h00;
      spareValid <= 1'b0;
      spare <= 8'h00;
    end
    else if (~outValid | outReady)
    begin
      // output entry free or draining
      if (spareValid)
      begin
        outData <= spare;
        outValid <= 1'b1;
        spareValid <= 1'b0;
      end
      else
      begin
        outData <= inData;
        outValid <= inValid;
      end
    end
    else if (inValid & inReady)
    begin
      // sink stalled, park the word
      spare <= inData;
      spareValid <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/ulms_top.sv ====
// line status, modem status, loopback and line driver control
// assumes a receiver and transmitter core on sys_clk beside it
`timescale 1ns/1ps
`default_nettype none

module ulms_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrStb,
  input wire logic sfrRdStb,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // receiver core
  input wire logic rxCharValid,
  input wire ulms_pkg::ulms_rxchar_t rxChar,
  output logic rxLineToCore,
  // transmitter core
  input wire logic txLineFromCore,
  input wire logic txShiftBusy,
  input wire logic txByteReady,
  output logic txByteValid,
  output logic [7:0] txByte,
  // line pins
  input wire logic rxdPin,
  input wire ulms_pkg::ulms_modem_t modemPinsN,
  output logic serialTxOut,
  output logic dtrN,
  output logic rtsN,
  output logic auxOutputOne,
  output logic auxOutputTwo,
  output logic driverEnableOut,
  output logic receiverEnableLow,
  // pending interrupt sources
  output logic rlsIrqPending,
  output logic txEmptyIrqPending,
  output logic msIrqPending
);

  ////////////////////////////////////////////////////////////////
  // declarations

  // register port decodes
  logic rdData, wrData, rdLsr, rdMsr, wrMcr;
  // modem control register
  logic [7:0] modemControl;
  logic loopSel;
  ulms_pkg::ulms_dir_t dirMode;
  // synchronised pins
  logic rxdSync;
  ulms_pkg::ulms_modem_t modemSync;
  // rx fifo
  ulms_pkg::ulms_rxchar_t rxMem [16];
  logic [3:0] rxWr, rxRd;
  logic [4:0] rxCount;
  logic rxPush, rxPop, rxFull, rxEmpty, overrunEvt;
  ulms_pkg::ulms_rxchar_t rxHead, rxIn;
  logic [15:0] errHeld;
  // tx fifo
  logic [7:0] txMem [16];
  logic [3:0] txWr, txRd;
  logic [4:0] txCount;
  logic txPush, txPop, skidInReady, txEmpty, txIdle;
  // line status flags
  logic overrun, headAck, headChange, errSummary;
  logic parityErr, framingErr, breakFlag, anyHeld;
  logic [7:0] lineStatus;
  // modem status
  ulms_pkg::ulms_modem_t pinLvl, prevLvl, chg;
  logic ctsChg, dsrChg, ringEdgeFlag, dcdChg, riRise;
  logic [7:0] modemStatus;
  logic [7:0] next_rdData;

  ////////////////////////////////////////////////////////////////
  // register port decode
  assign rdData = sfrRdStb & (sfrAddr == ulms_pkg::ADDR_DATA);
  assign wrData = sfrWrStb & (sfrAddr == ulms_pkg::ADDR_DATA);
  assign rdLsr = sfrRdStb & (sfrAddr == ulms_pkg::ADDR_LSR);
  assign rdMsr = sfrRdStb & (sfrAddr == ulms_pkg::ADDR_MSR);
  assign wrMcr = sfrWrStb & (sfrAddr == ulms_pkg::ADDR_MCR);

  // modem control is write only
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      modemControl <= ulms_pkg::MCR_RESET;
    else if (wrMcr)
      modemControl <= sfrWrData;
  end

  assign loopSel = modemControl[ulms_pkg::MCR_LOOP];
  assign dirMode = ulms_pkg::ulms_dir_t'(
    modemControl[ulms_pkg::MCR_DIR_HI:ulms_pkg::MCR_DIR_LO]);

  ////////////////////////////////////////////////////////////////
  // pin synchronisers, idle high
  ulms_sync #(.W(5), .INIT(5'h1F)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn({rxdPin, modemPinsN}),
    .syncOut({rxdSync, modemSync})
  );

  ////////////////////////////////////////////////////////////////
  // rx fifo
  assign rxFull = (rxCount == ulms_pkg::FIFO_DEPTH);
  assign rxEmpty = (rxCount == ulms_pkg::FIFO_ZERO);
  assign rxPop = rdData & ~rxEmpty;
  // full fifo drops the new character
  assign rxPush = rxCharValid & ~rxFull;
  assign overrunEvt = rxCharValid & rxFull;
  assign rxHead = rxMem[rxRd];

  // break stores an all-zero character
  always_comb
  begin
    rxIn = rxChar;
    if (rxChar.brk)
      rxIn.data = 8'h00;
  end

  // storage
  always_ff @(posedge sys_clk)
  begin
    if (rxPush)
      rxMem[rxWr] <= rxIn;
  end

  // pointers and count
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rxWr <= 4'h0;
      rxRd <= 4'h0;
      rxCount <= ulms_pkg::FIFO_ZERO;
    end
    else
    begin
      if (rxPush)
        rxWr <= rxWr + ulms_pkg::PTR_ONE;
      if (rxPop)
        rxRd <= rxRd + ulms_pkg::PTR_ONE;
      // push and pop together keep the count
      if (rxPush & ~rxPop)
        rxCount <= rxCount + ulms_pkg::FIFO_ONE;
      else if (rxPop & ~rxPush)
        rxCount <= rxCount - ulms_pkg::FIFO_ONE;
    end
  end

  // error marks of occupied entries
  genvar gi;
  for (gi = 0; gi < 16; gi++)
  begin : g_err
    logic [3:0] off;
    assign off = 4'(gi) - rxRd;
    assign errHeld[gi] = ({1'b0, off} < rxCount) &
      (rxMem[gi].parityBad | rxMem[gi].stopBad | rxMem[gi].brk);
  end
  assign anyHeld = |errHeld;

  ////////////////////////////////////////////////////////////////
  // tx fifo, feeding the transmitter through the buffer
  assign txEmpty = (txCount == ulms_pkg::FIFO_ZERO);
  // write to a full fifo is dropped
  assign txPush = wrData & (txCount != ulms_pkg::FIFO_DEPTH);
  assign txPop = ~txEmpty & skidInReady;

  // storage
  always_ff @(posedge sys_clk)
  begin
    if (txPush)
      txMem[txWr] <= sfrWrData;
  end

  // pointers and count
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      txWr <= 4'h0;
      txRd <= 4'h0;
      txCount <= ulms_pkg::FIFO_ZERO;
    end
    else
    begin
      if (txPush)
        txWr <= txWr + ulms_pkg::PTR_ONE;
      if (txPop)
        txRd <= txRd + ulms_pkg::PTR_ONE;
      if (txPush & ~txPop)
        txCount <= txCount + ulms_pkg::FIFO_ONE;
      else if (txPop & ~txPush)
        txCount <= txCount - ulms_pkg::FIFO_ONE;
    end
  end

  // stalled transmitter backs up into the fifo
  ulms_skid u_skid (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid(~txEmpty),
    .inData(txMem[txRd]),
    .inReady(skidInReady),
    .outReady(txByteReady),
    .outValid(txByteValid),
    .outData(txByte)
  );

  // nothing queued, buffered or shifting
  assign txIdle = txEmpty & ~txByteValid & ~txShiftBusy;

  ////////////////////////////////////////////////////////////////
  // line status flags
  // head changes on pop or on first push
  assign headChange = rxPop | (rxPush & rxEmpty);

  // overrun, set wins over read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      overrun <= 1'b0;
    else if (overrunEvt)
      overrun <= 1'b1;
    else if (rdLsr)
      overrun <= 1'b0;
  end

  // head flags hidden after a read until head changes
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      headAck <= 1'b0;
    else if (headChange)
      headAck <= 1'b0;
    else if (rdLsr)
      headAck <= 1'b1;
  end

  // summary follows held errors, read clears otherwise
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      errSummary <= 1'b0;
    else if (anyHeld)
      errSummary <= 1'b1;
    else if (rdLsr)
      errSummary <= 1'b0;
  end

  // head character marks
  assign parityErr = ~rxEmpty & ~headAck & rxHead.parityBad;
  assign framingErr = ~rxEmpty & ~headAck & rxHead.stopBad;
  assign breakFlag = ~rxEmpty & ~headAck & rxHead.brk;

  // assembled line status
  assign lineStatus = {errSummary, txIdle, txEmpty, breakFlag,
    framingErr, parityErr, overrun, ~rxEmpty};

  ////////////////////////////////////////////////////////////////
  // modem inputs, loopback replaces the pins
  always_comb
  begin
    pinLvl = modemSync;
    if (loopSel)
    begin
      pinLvl.cts = ~modemControl[ulms_pkg::MCR_RTS];
      pinLvl.dsr = ~modemControl[ulms_pkg::MCR_DTR];
      pinLvl.ri = ~modemControl[ulms_pkg::MCR_AUX1];
      pinLvl.dcd = ~modemControl[ulms_pkg::MCR_AUX2];
    end
  end

  // previous sample for change detection
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prevLvl <= ulms_pkg::MODEM_IDLE;
    else
      prevLvl <= pinLvl;
  end

  assign chg = pinLvl ^ prevLvl;
  assign riRise = pinLvl.ri & ~prevLvl.ri;

  // change flags, set wins over read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctsChg <= 1'b0;
      dsrChg <= 1'b0;
      ringEdgeFlag <= 1'b0;
      dcdChg <= 1'b0;
    end
    else
    begin
      ctsChg <= chg.cts | (ctsChg & ~rdMsr);
      dsrChg <= chg.dsr | (dsrChg & ~rdMsr);
      ringEdgeFlag <= riRise | (ringEdgeFlag & ~rdMsr);
      dcdChg <= chg.dcd | (dcdChg & ~rdMsr);
    end
  end

  // levels are the complement of the pins
  assign modemStatus = {~pinLvl.dcd, ~pinLvl.ri, ~pinLvl.dsr,
    ~pinLvl.cts, dcdChg, ringEdgeFlag, dsrChg, ctsChg};

  ////////////////////////////////////////////////////////////////
  // read data, registered on the strobe
  always_comb
  begin
    next_rdData = ulms_pkg::READ_NONE;
    case (sfrAddr)
      ulms_pkg::ADDR_DATA: next_rdData = rxHead.data;
      ulms_pkg::ADDR_LSR: next_rdData = lineStatus;
      ulms_pkg::ADDR_MSR: next_rdData = modemStatus;
      default: next_rdData = ulms_pkg::READ_NONE;
    endcase
    if (rxEmpty & (sfrAddr == ulms_pkg::ADDR_DATA))
      next_rdData = ulms_pkg::READ_NONE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sfrRdData <= ulms_pkg::READ_NONE;
    else if (sfrRdStb)
      sfrRdData <= next_rdData;
  end

  ////////////////////////////////////////////////////////////////
  // serial path and loopback
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      serialTxOut <= 1'b1;
      rxLineToCore <= 1'b1;
    end
    else
    begin
      serialTxOut <= loopSel | txLineFromCore;
      rxLineToCore <= loopSel ? txLineFromCore : rxdSync;
    end
  end

  // modem output pins, DTR and RTS inverted control bits, aux outputs direct
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dtrN <= 1'b1;
      rtsN <= 1'b1;
      auxOutputOne <= 1'b0;
      auxOutputTwo <= 1'b0;
    end
    else
    begin
      dtrN <= ~modemControl[ulms_pkg::MCR_DTR];
      rtsN <= ~modemControl[ulms_pkg::MCR_RTS];
      auxOutputOne <= modemControl[ulms_pkg::MCR_AUX1];
      auxOutputTwo <= modemControl[ulms_pkg::MCR_AUX2];
    end
  end

  // line driver direction
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      driverEnableOut <= 1'b0;
      receiverEnableLow <= 1'b1;
    end
    else
    begin
      driverEnableOut <= ~txEmpty;
      case (dirMode)
        ulms_pkg::DIR_RX_OFF: receiverEnableLow <= 1'b1;
        ulms_pkg::DIR_HALF: receiverEnableLow <= ~txIdle;
        default: receiverEnableLow <= 1'b0;
      endcase
    end
  end

  // pending interrupt sources, line and modem ones cleared by the status reads
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rlsIrqPending <= 1'b0;
      txEmptyIrqPending <= 1'b0;
      msIrqPending <= 1'b0;
    end
    else
    begin
      rlsIrqPending <= overrun | parityErr | framingErr | breakFlag;
      txEmptyIrqPending <= txEmpty;
      msIrqPending <= ctsChg | dsrChg | ringEdgeFlag | dcdChg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_LOOP_TX_HIGH: assert property (loopSel |=> serialTxOut)
    else $error("serial out not high in loopback");
  AST_LOOP_RX_PATH: assert property (loopSel |=>
    rxLineToCore == $past(txLineFromCore))
    else $error("loopback rx path broken");
  // status nibble order is aux two, aux one, dtr, rts
  AST_LOOP_MSR: assert property (loopSel && rdMsr |=>
    sfrRdData[7:4] == $past({modemControl[ulms_pkg::MCR_AUX2],
    modemControl[ulms_pkg::MCR_AUX1], modemControl[ulms_pkg::MCR_DTR],
    modemControl[ulms_pkg::MCR_RTS]}))
    else $error("loopback modem levels wrong");
  AST_DE: assert property (!txEmpty |=> driverEnableOut)
    else $error("driver enable low with data queued");
  AST_RE_HALF: assert property (dirMode == ulms_pkg::DIR_HALF &&
    txShiftBusy |=> receiverEnableLow)
    else $error("receiver enabled while sending");
  AST_RE_FULL: assert property (dirMode[1] |=> !receiverEnableLow)
    else $error("receiver disabled in full duplex");
  AST_DR: assert property (rdLsr |=>
    sfrRdData[ulms_pkg::LSR_DATA_PRESENT] == $past(!rxEmpty))
    else $error("data present flag wrong");
  AST_OVERRUN: assert property (overrunEvt && !rxPop |=>
    overrun && rxCount == ulms_pkg::FIFO_DEPTH)
    else $error("overrun not flagged or fifo changed");
  AST_TX_FIFO_EMPTY_FLAG: assert property (rdLsr |=>
    sfrRdData[ulms_pkg::LSR_TX_EMPTY] == $past(txEmpty))
    else $error("tx empty flag wrong");
  // a new head in the read cycle brings its own marks back
  AST_OE_CLEAR: assert property (rdLsr && !overrunEvt && !headChange |=>
    !overrun ##1 !rlsIrqPending || overrun)
    else $error("overrun not cleared by read");
  AST_CTS_CHG: assert property (chg.cts |=> ctsChg)
    else $error("cts change lost");
  AST_RING_EDGE: assert property ($rose(ringEdgeFlag) |->
    $past(pinLvl.ri) && !$past(prevLvl.ri))
    else $error("ring flag without trailing edge");
  AST_DTR: assert property (wrMcr |=> ##1
    dtrN == !$past(sfrWrData[ulms_pkg::MCR_DTR], 2))
    else $error("dtr pin not inverted control bit");

  COV_OVERRUN: cover property (overrunEvt ##[1:20] rdLsr);
  COV_LOOP_READ: cover property (loopSel && rdMsr);
  COV_RING_EDGE: cover property (riRise ##[1:20] rdMsr);

endmodule

`default_nettype wire

// ==== dv/ulms_line_model.sv ====
// far side model: transmitter core shifting bytes onto the serial line
// assumes the block's sys_clk; stall makes it refuse bytes
`timescale 1ns/1ps
`default_nettype none

module ulms_line_model (
  // clock and pacing
  input wire logic sys_clk,
  input wire logic stall,
  // byte handshake
  input wire logic txByteValid,
  input wire logic [7:0] txByte,
  output logic txByteReady,
  output logic took,
  output logic [7:0] tookByte,
  // shifter side
  output logic txShiftBusy,
  output logic txLineFromCore
);
  logic [3:0] cnt = 4'h0; // bit times left
  logic [7:0] sh = 8'hFF; // byte being shifted
  initial
  begin
    took = 1'b0;
    tookByte = 8'h00;
    txLineFromCore = 1'b1;
  end
  // accept only when idle and not stalled
  assign txByteReady = !stall && cnt == 4'h0;
  assign txShiftBusy = cnt != 4'h0;
  // start bit, eight data bits lsb first, stop
  always @(posedge sys_clk)
  begin
    took <= txByteValid && txByteReady;
    tookByte <= txByte;
    if (txByteValid && txByteReady)
    begin
      cnt <= 4'h9;
      sh <= txByte;
      txLineFromCore <= 1'b0;
    end
    else if (cnt != 4'h0)
    begin
      cnt <= cnt - 4'h1;
      txLineFromCore <= (cnt == 4'h1) ? 1'b1 : sh[0];
      sh <= {1'b1, sh[7:1]};
    end
  end
endmodule

`default_nettype wire

// ==== dv/ulms_top_tb.sv ====
// self-checking bench for the line and modem status block
// assumes the package and design files compiled first
`timescale 1ns/1ps
`default_nettype none

module ulms_top_tb;
  ////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWrStb = 1'b0;
  logic sfrRdStb = 1'b0;
  logic [7:0] sfrRdData;
  logic rxCharValid = 1'b0;
  ulms_pkg::ulms_rxchar_t rxChar = '0;
  ulms_pkg::ulms_modem_t modemPinsN = ulms_pkg::MODEM_IDLE;
  ulms_pkg::ulms_modem_t old;
  logic rxdPin = 1'b1;
  logic stall = 1'b0;
  logic rxLineToCore, txLineFromCore, txShiftBusy, txByteReady, txByteValid;
  logic [7:0] txByte, tookByte;
  logic serialTxOut, dtrN, rtsN, auxOutputOne, auxOutputTwo, took;
  logic driverEnableOut, receiverEnableLow, rlsIrqPending, txEmptyIrqPending, msIrqPending;
  logic [15:0] rdQ[$]; // expected reads: mask, value
  logic [7:0] txQ[$]; // expected bytes to transmitter
  logic [15:0] note;
  logic [10:0] c;
  logic [7:0] b;
  logic [3:0] d;
  logic rdLate = 1'b0;
  logic lastLine;
  int failCount = 0;
  int nCompared = 0;
  int cycles = 0;

  ulms_top ulms_top_inst (.sys_clk, .rst, .sfrAddr, .sfrWrStb, .sfrRdStb, .sfrWrData,
    .sfrRdData, .rxCharValid, .rxChar, .rxLineToCore, .txLineFromCore, .txShiftBusy,
    .txByteReady, .txByteValid, .txByte, .rxdPin, .modemPinsN, .serialTxOut, .dtrN,
    .rtsN, .auxOutputOne, .auxOutputTwo, .driverEnableOut, .receiverEnableLow,
    .rlsIrqPending, .txEmptyIrqPending, .msIrqPending);

  ulms_line_model ulms_line_model_inst (.sys_clk, .stall, .txByteValid, .txByte,
    .txByteReady, .took, .tookByte, .txShiftBusy, .txLineFromCore);

  ////////////////////////////////////////////////////////////////
  // clock, timeout and closing report
  always #4 sys_clk = !sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failCount++;
      stopTest();
    end
  end
  task automatic stopTest();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // bus and receiver drivers, noting expectations
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    sfrAddr = a;
    sfrWrData = v;
    sfrWrStb = 1'b1;
    @(negedge sys_clk);
    sfrWrStb = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge sys_clk);
    sfrAddr = a;
    sfrRdStb = 1'b1;
    rdQ.push_back({m, e & m});
    @(negedge sys_clk);
    sfrRdStb = 1'b0;
  endtask
  task automatic push(input logic [10:0] v);
    @(negedge sys_clk);
    rxChar = v;
    rxCharValid = 1'b1;
    @(negedge sys_clk);
    rxCharValid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  // watcher: read data the cycle after a read, bytes as taken
  always @(posedge sys_clk) rdLate <= sfrRdStb;
  always @(negedge sys_clk)
  begin
    if (rdLate)
    begin
      note = rdQ.pop_front();
      check("read", sfrRdData & note[15:8], note[7:0]);
    end
    if (took)
      check("txByte", tookByte, txQ.pop_front());
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(32'h88EC));
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    // values after reset
    rd(ulms_pkg::ADDR_LSR, 8'h60, 8'hFF);
    rd(ulms_pkg::ADDR_MSR, 8'h00, 8'hFF);
    rd(8'h33, ulms_pkg::READ_NONE, 8'hFF);
    check("txIrq", txEmptyIrqPending, 1'b1);
    // control pins, all sixteen patterns
    for (int i = 0; i < 16; i++)
    begin
      wr(ulms_pkg::ADDR_MCR, i[7:0]);
      @(negedge sys_clk);
      check("dtrN", dtrN, !i[0]);
      check("rtsN", rtsN, !i[1]);
      check("aux", {auxOutputTwo, auxOutputOne}, i[3:2]);
    end
    // loopback routing of control bits to modem status
    for (int i = 0; i < 8; i++)
    begin
      b = 8'($urandom) & 8'h0F | 8'h10;
      wr(ulms_pkg::ADDR_MCR, b);
      repeat (4) @(negedge sys_clk);
      rd(ulms_pkg::ADDR_MSR, {b[3], b[2], b[0], b[1], 4'h0}, 8'hF0);
      check("txOut", serialTxOut, 1'b1);
    end
    wr(ulms_pkg::ADDR_MCR, 8'h00);
    repeat (6) @(negedge sys_clk);
    rd(ulms_pkg::ADDR_MSR, 8'h00, 8'hF0);
    // random modem pin changes, flags cleared by read
    for (int i = 0; i < 12; i++)
    begin
      old = modemPinsN;
      modemPinsN = 4'($urandom);
      rxdPin = 1'($urandom);
      repeat (6) @(negedge sys_clk);
      check("rxLine", rxLineToCore, rxdPin);
      d = old ^ modemPinsN;
      d[2] = !old[2] && modemPinsN[2];
      check("msIrq", msIrqPending, |d);
      rd(ulms_pkg::ADDR_MSR, {~modemPinsN, d}, 8'hFF);
      @(negedge sys_clk);
      check("msIrqClr", msIrqPending, 1'b0);
    end
    // parity, framing and break characters at the head
    for (int k = 0; k < 3; k++)
    begin
      c = 11'($urandom);
      c[10:8] = 3'h1 << k;
      push(c);
      push(11'h0A5);
      check("rlsIrq", rlsIrqPending, 1'b1);
      rd(ulms_pkg::ADDR_LSR, 8'hE1 | (8'h04 << k), 8'hFF);
      @(negedge sys_clk);
      check("rlsIrqClr", rlsIrqPending, 1'b0);
      rd(ulms_pkg::ADDR_LSR, 8'hE1, 8'hFF);
      rd(ulms_pkg::ADDR_DATA, (k == 2) ? 8'h00 : c[7:0], 8'hFF);
      rd(ulms_pkg::ADDR_LSR, 8'hE1, 8'hFF);
      rd(ulms_pkg::ADDR_DATA, 8'hA5, 8'hFF);
      rd(ulms_pkg::ADDR_LSR, 8'h60, 8'hFF);
    end
    // overrun: seventeen characters into sixteen places
    for (int i = 0; i < 17; i++)
      push({3'h0, i[7:0]});
    rd(ulms_pkg::ADDR_LSR, 8'h63, 8'hFF);
    rd(ulms_pkg::ADDR_LSR, 8'h61, 8'hFF);
    for (int i = 0; i < 16; i++)
      rd(ulms_pkg::ADDR_DATA, i[7:0], 8'hFF);
    rd(ulms_pkg::ADDR_DATA, 8'h00, 8'hFF);
    rd(ulms_pkg::ADDR_LSR, 8'h60, 8'hFF);
    // receiver enable in each direction mode while idle
    for (int m = 0; m < 4; m++)
    begin
      wr(ulms_pkg::ADDR_MCR, {m[1:0], 6'h00});
      repeat (2) @(negedge sys_clk);
      check("reLow", receiverEnableLow, m == 0);
    end
    // half duplex loopback transmit with a stalling far side
    wr(ulms_pkg::ADDR_MCR, 8'h50);
    stall = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      b = 8'($urandom);
      txQ.push_back(b);
      wr(ulms_pkg::ADDR_DATA, b);
    end
    rd(ulms_pkg::ADDR_LSR, 8'h00, 8'h60);
    @(negedge sys_clk);
    check("drvEn", driverEnableOut, 1'b1);
    check("txIrqBusy", txEmptyIrqPending, 1'b0);
    check("reLowBusy", receiverEnableLow, 1'b1);
    lastLine = txLineFromCore;
    for (int i = 0; i < 600 && txQ.size() > 0; i++)
    begin
      @(negedge sys_clk);
      check("loop", rxLineToCore, lastLine);
      check("txOutLoop", serialTxOut, 1'b1);
      lastLine = txLineFromCore;
      stall = 1'($urandom);
      rxdPin = 1'($urandom);
    end
    stall = 1'b0;
    repeat (14) @(negedge sys_clk);
    check("drvEnIdle", driverEnableOut, 1'b0);
    check("reLowIdle", receiverEnableLow, 1'b0);
    rd(ulms_pkg::ADDR_LSR, 8'h60, 8'hFF);
    check("txLeft", 8'(txQ.size()), 8'h00);
    @(negedge sys_clk);
    stopTest();
  end
endmodule

`default_nettype wire
